// File: rtl/channel_command_executor.sv
// Command register executor with its APB register file.
// Assumes serial datapaths that act on the enable, flush and special
// character outputs, and a transmitter that takes sc_valid ahead of its FIFO.
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
module channel_command_executor #(
  parameter logic [7:0] FW_REV   = 8'h5a, // Arbitrary nonzero value.
  parameter int         RST_CYC  = 16,    // Cycles an internal reset lasts.
  parameter int         AW       = 12
) (
  input  wire logic          pclk,       // System clock, 100 MHz.
  input  wire logic          presetn,    // Asynchronous reset, active low.
  input  wire logic          psel,       // APB select.
  input  wire logic          penable,    // APB enable.
  input  wire logic          pwrite,     // APB direction.
  input  wire logic [AW-1:0] paddr,      // APB byte address.
  input  wire logic [31:0]   pwdata,     // APB write data.
  output logic      [31:0]   prdata,     // APB read data.
  output logic               pready,     // APB ready.
  output logic               pslverr,    // APB error, unmapped or unaligned address.
  output logic      [1:0]    tx_en,      // Transmitter enable, ch 3 and 2.
  output logic      [1:0]    rx_en,      // Receiver enable, ch 3 and 2.
  output logic      [1:0]    tx_flush,   // Transmit FIFO flush pulse.
  output logic      [1:0]    rx_flush,   // Receive FIFO flush pulse.
  output logic               chip_reset, // Full reset pulse to the chip.
  output logic      [47:0]   opt_shadow, // Shadow option bytes, ch 3 and 2.
  output logic               sc_valid,   // Special character pending.
  output logic      [7:0]    sc_char,    // Special character to send.
  output logic               sc_chan,    // Channel of it: 0 is ch 2.
  input  wire logic          sc_taken    // Transmitter took the character.
);
  localparam logic [7:0] RST_LAST = 8'(RST_CYC - 1);

  typedef struct packed {
    chan_cmd_pkg::st_t          st;
    logic [7:0]                 cmd;
    logic [1:0]                 cmd_ch;
    logic [1:0]                 sel;
    logic [7:0]                 fw;
    logic [7:0]                 cnt;
    logic [1:0]                 tx_en;
    logic [1:0]                 rx_en;
    logic [1:0]                 tx_fl;
    logic [1:0]                 rx_fl;
    logic                       chip_rst;
    logic                       mem_clr;
    logic [1:0][2:0][7:0]       shadow;
    logic [1:0]                 step;
    logic                       sc_v;
    logic [7:0]                 sc_c;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
  } s_t;

  s_t r_ff;
  s_t nxt_r;

  logic [7:0]          idx;
  logic                aligned;
  logic [3:0]          slot;
  logic                wr_now;
  logic                rd_now;
  logic                cmd_wr;
  logic                s;
  logic [4:0]          raddr_a;
  logic [4:0]          raddr_b;
  logic [7:0]          mem_ra;
  logic [7:0]          mem_rb;
  logic                mem_we;
  chan_cmd_pkg::kind_t kind;

  assign idx     = paddr[9:2];
  assign aligned = (paddr[AW-1:10] == '0) && (paddr[1:0] == 2'h0);
  assign slot    = chan_cmd_pkg::slot_of_f(idx);
  assign rd_now  = psel && penable && !r_ff.pready;
  assign wr_now  = psel && penable && r_ff.pready && pwrite && !r_ff.pslverr;
  assign cmd_wr  = wr_now && (idx == chan_cmd_pkg::IDX_CMD);
  assign s       = r_ff.cmd_ch[0];
  assign kind    = chan_cmd_pkg::cmd_kind_f(r_ff.cmd);
  // Option and special bytes are banked by the selected channel.
  assign raddr_a = {r_ff.sel, slot[2:0]}; // R1
  assign mem_we  = wr_now && slot[3];
  assign raddr_b = (r_ff.st == chan_cmd_pkg::ST_SCRD) ?
                   {r_ff.cmd_ch, r_ff.cmd[2:0] + chan_cmd_pkg::SLOT_SC1
                    - 3'h1} : // R18
                   {r_ff.cmd_ch, 1'b0, r_ff.step};

  chan_regs_mem #(
    .AW (5),
    .DW (8)
  ) u_mem (
    .clk     (pclk),
    .rst_n   (presetn),
    .clr     (r_ff.mem_clr),
    .we      (mem_we),
    .waddr   (raddr_a),
    .wdata   (pwdata[7:0]),
    .raddr_a (raddr_a),
    .raddr_b (raddr_b),
    .rdata_a (mem_ra),
    .rdata_b (mem_rb)
  );

  always_comb begin
    nxt_r          = r_ff;
    nxt_r.tx_fl    = 2'h0;
    nxt_r.rx_fl    = 2'h0;
    nxt_r.chip_rst = 1'b0;
    nxt_r.mem_clr  = 1'b0;
    case (r_ff.st)
      chan_cmd_pkg::ST_BOOT: begin
        nxt_r.cnt = r_ff.cnt + 8'h01;
        if (r_ff.cnt >= RST_LAST) begin
          nxt_r.fw  = FW_REV; // R10
          nxt_r.cmd = 8'h00; // R3
          nxt_r.st  = chan_cmd_pkg::ST_IDLE;
        end
      end
      chan_cmd_pkg::ST_IDLE: begin
        if (r_ff.cmd != 8'h00) begin
          nxt_r.st = chan_cmd_pkg::ST_DEC;
        end
      end
      chan_cmd_pkg::ST_DEC: begin
        nxt_r.st   = chan_cmd_pkg::ST_IDLE;
        nxt_r.cmd  = 8'h00; // R3
        nxt_r.step = 2'h0;
        case (kind) // R2 R7
          chan_cmd_pkg::K_CHRST: begin
            nxt_r.tx_en[s] = 1'b0; // R8
            nxt_r.rx_en[s] = 1'b0; // R8
            nxt_r.tx_fl[s] = 1'b1; // R8
            nxt_r.rx_fl[s] = 1'b1; // R8
            nxt_r.fw       = 8'h00; // R10
            nxt_r.cnt      = 8'h00;
            nxt_r.cmd      = r_ff.cmd;
            nxt_r.st       = chan_cmd_pkg::ST_BOOT;
          end
          chan_cmd_pkg::K_FULL: begin
            // Same end state as the reset pin, then the boot count runs.
            nxt_r          = '0; // R9
            nxt_r.chip_rst = 1'b1; // R9
            nxt_r.tx_fl    = 2'h3; // R9
            nxt_r.rx_fl    = 2'h3; // R9
            nxt_r.mem_clr  = 1'b1; // R9
          end
          chan_cmd_pkg::K_FLUSH: begin
            nxt_r.tx_fl[s] = 1'b1; // R12
          end
          chan_cmd_pkg::K_OPT: begin
            nxt_r.cmd = r_ff.cmd;
            nxt_r.st  = chan_cmd_pkg::ST_OPT; // R13
          end
          chan_cmd_pkg::K_SC: begin
            nxt_r.cmd = r_ff.cmd;
            nxt_r.st  = chan_cmd_pkg::ST_SCRD; // R15
          end
          chan_cmd_pkg::K_CTL: begin
            if (r_ff.cmd[chan_cmd_pkg::B_TXEN]) begin
              nxt_r.tx_en[s] = 1'b1; // R19
            end
            if (r_ff.cmd[chan_cmd_pkg::B_TXDIS]) begin
              nxt_r.tx_en[s] = 1'b0; // R19
            end
            if (r_ff.cmd[chan_cmd_pkg::B_RXEN]) begin
              nxt_r.rx_en[s] = 1'b1; // R19
            end
            if (r_ff.cmd[chan_cmd_pkg::B_RXDIS]) begin
              nxt_r.rx_en[s] = 1'b0; // R19
            end
          end
          default: begin
            nxt_r.st = chan_cmd_pkg::ST_IDLE; // R20
          end
        endcase
      end
      chan_cmd_pkg::ST_OPT: begin
        // Step k reads slot k; the byte of slot k-1 arrives meanwhile.
        nxt_r.step = r_ff.step + 2'h1;
        if (r_ff.step != 2'h0 && r_ff.cmd[r_ff.step]) begin
          nxt_r.shadow[s][r_ff.step - 2'h1] = mem_rb; // R14
        end
        if (r_ff.step == 2'h3) begin
          nxt_r.cmd = 8'h00; // R3
          nxt_r.st  = chan_cmd_pkg::ST_IDLE;
        end
      end
      chan_cmd_pkg::ST_SCRD: begin
        nxt_r.step = 2'h1;
        if (r_ff.step == 2'h1) begin
          nxt_r.sc_c = mem_rb; // R15
          nxt_r.sc_v = 1'b1; // R17
          nxt_r.st   = chan_cmd_pkg::ST_SCO;
        end
      end
      chan_cmd_pkg::ST_SCO: begin
        // Held until the transmitter slots it in after the holding byte.
        if (sc_taken) begin
          nxt_r.sc_v = 1'b0; // R16
          nxt_r.cmd  = 8'h00; // R3
          nxt_r.st   = chan_cmd_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_r.st = chan_cmd_pkg::ST_IDLE;
      end
    endcase

    // One wait state: read data and error come with pready.
    nxt_r.pready = rd_now;
    if (rd_now) begin
      nxt_r.pslverr = 1'b0;
      nxt_r.prdata  = 32'h0000_0000;
      if (!aligned) begin
        nxt_r.pslverr = 1'b1;
      end else if (idx == chan_cmd_pkg::IDX_CMD) begin
        if (r_ff.sel == r_ff.cmd_ch) begin
          nxt_r.prdata[7:0] = r_ff.cmd; // R1
        end
      end else if (idx == chan_cmd_pkg::IDX_CHSEL) begin
        nxt_r.prdata[1:0] = r_ff.sel;
      end else if (idx == chan_cmd_pkg::IDX_FWREV) begin
        nxt_r.prdata[7:0] = r_ff.fw;
      end else if (idx == chan_cmd_pkg::IDX_STAT) begin
        nxt_r.prdata[4:0] = {r_ff.tx_en, r_ff.rx_en,
                             r_ff.st != chan_cmd_pkg::ST_IDLE};
      end else if (slot[3]) begin
        nxt_r.prdata[7:0] = mem_ra;
      end else begin
        nxt_r.pslverr = 1'b1;
      end
    end
    if (wr_now) begin
      if (idx == chan_cmd_pkg::IDX_CHSEL) begin
        nxt_r.sel = pwdata[1:0]; // R1
      end else if (idx == chan_cmd_pkg::IDX_FWREV &&
                   !(r_ff.st == chan_cmd_pkg::ST_BOOT &&
                     r_ff.cnt >= RST_LAST)) begin // R10
        // The boot-end load wins over a host write in the same cycle.
        nxt_r.fw = pwdata[7:0];
      end else if (cmd_wr && r_ff.cmd == 8'h00 &&
                   r_ff.st == chan_cmd_pkg::ST_IDLE &&
                   chan_cmd_pkg::is_serial_f(r_ff.sel)) begin // R5
        nxt_r.cmd    = pwdata[7:0];
        nxt_r.cmd_ch = r_ff.sel;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign prdata     = r_ff.prdata;
  assign pready     = r_ff.pready;
  assign pslverr    = r_ff.pslverr;
  assign tx_en      = r_ff.tx_en;
  assign rx_en      = r_ff.rx_en;
  assign tx_flush   = r_ff.tx_fl;
  assign rx_flush   = r_ff.rx_fl;
  assign chip_reset = r_ff.chip_rst;
  assign opt_shadow = r_ff.shadow;
  assign sc_valid   = r_ff.sc_v;
  assign sc_char    = r_ff.sc_c;
  assign sc_chan    = s;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic in_dec;
  assign in_dec = (r_ff.st == chan_cmd_pkg::ST_DEC);

  sequence flush_once_s;
    (tx_flush != 2'h0 && rx_flush == 2'h0) ##1 (tx_flush == 2'h0);
  endsequence

  sequence boot_zero_s;
    (r_ff.fw == 8'h00 && r_ff.st == chan_cmd_pkg::ST_BOOT) [*2];
  endsequence

  ignore_chan_a: assert property ( // R5
    cmd_wr && !chan_cmd_pkg::is_serial_f(r_ff.sel) && r_ff.cmd == 8'h00
    |=> r_ff.cmd == 8'h00)
    else $error("command accepted on a non-serial channel");

  noop_clear_a: assert property ( // R20
    in_dec && kind == chan_cmd_pkg::K_NOOP
    |=> r_ff.cmd == 8'h00 && r_ff.st == chan_cmd_pkg::ST_IDLE)
    else $error("unused command not cleared");

  opt_done_a: assert property ( // R3
    in_dec && kind == chan_cmd_pkg::K_OPT
    |=> ##4 (r_ff.cmd == 8'h00 && r_ff.st == chan_cmd_pkg::ST_IDLE))
    else $error("option change did not finish in five cycles");

  full_reset_a: assert property ( // R9
    in_dec && kind == chan_cmd_pkg::K_FULL
    |=> chip_reset && r_ff.sel == 2'h0 && tx_en == 2'h0 && rx_en == 2'h0)
    else $error("full reset left state behind");

  fw_clear_a: assert property ( // R10
    in_dec && kind == chan_cmd_pkg::K_CHRST |=> boot_zero_s)
    else $error("revision not cleared at reset start");

  fw_load_a: assert property ( // R10
    r_ff.st == chan_cmd_pkg::ST_BOOT ##1 r_ff.st == chan_cmd_pkg::ST_IDLE
    |-> r_ff.fw == FW_REV)
    else $error("revision not loaded at reset end");

  flush_pulse_a: assert property ( // R12
    in_dec && kind == chan_cmd_pkg::K_FLUSH |=> flush_once_s)
    else $error("transmit flush not a single pulse");

  ctl_enable_a: assert property ( // R19
    in_dec && kind == chan_cmd_pkg::K_CTL && r_ff.cmd[3]
    |=> tx_en[$past(s)])
    else $error("transmitter not enabled");

  sc_hold_a: assert property ( // R16
    sc_valid && !sc_taken |=> sc_valid && $stable(sc_char))
    else $error("special character dropped before taken");
endmodule // channel_command_executor

// File: pkg/chan_cmd_pkg.sv
// Constants, types and decode helpers for the channel command executor.
// Assumes an APB slave with 32-bit data and four channels, 2 and 3 serial.
// What this block does
// (R1) Per-channel register accesses target the channel in the select register.
// (R2) Command upper nibble is a one-hot type, lower nibble its parameters.
// (R3) After executing a command the device clears the command register.
// (R4) Host waits for the command register to read zero before writing again.
// (R5) Commands act only on channels 2 and 3; others are ignored.
// (R6) Host selects channel 2 or 3 before asking for a full reset.
// (R7) Reset command: bit 7, bits 6:2 zero; 00 chan, 01 chip, 10 flush.
// (R8) Channel reset disables receiver and transmitter and flushes its FIFOs.
// (R9) Full reset acts like hardware reset: all disabled, flushed, defaulted.
// (R10) Any reset clears the revision register, then loads the nonzero value.
// (R11) Host detects reset end by revision going zero then nonzero.
// (R12) Flush parameter empties the selected serial transmit FIFO.
// (R13) Option change: bit 6, bits 3:1 flag option registers three..one.
// (R14) Option change reloads shadow copies of the flagged option registers.
// (R15) Send special: bit 5, bits 2:0 choose one of four characters.
// (R16) Special character goes right after the holding register, ahead of FIFO.
// (R17) Send special applies to serial channels only.
// (R18) Codes 1 to 4 choose characters one to four; others unused.
// (R19) Channel control: bits 3:0 are tx enable, tx disable, rx en, rx dis.
// (R20) Unused encodings do nothing but still clear the command register.
package chan_cmd_pkg;
  localparam logic [7:0] IDX_OPT1  = 8'h01;
  localparam logic [7:0] IDX_OPT3  = 8'h03;
  localparam logic [7:0] IDX_CMD   = 8'h05;
  localparam logic [7:0] IDX_SC1   = 8'h06;
  localparam logic [7:0] IDX_SC4   = 8'h09;
  localparam logic [7:0] IDX_CHSEL = 8'h0c;
  localparam logic [7:0] IDX_FWREV = 8'h0d;
  localparam logic [7:0] IDX_STAT  = 8'h0e;
  localparam logic [2:0] SLOT_SC1  = 3'h3;
  localparam int         B_RST     = 7;
  localparam int         B_OPT     = 6;
  localparam int         B_SC      = 5;
  localparam int         B_CTL     = 4;
  localparam int         B_TXEN    = 3;
  localparam int         B_TXDIS   = 2;
  localparam int         B_RXEN    = 1;
  localparam int         B_RXDIS   = 0;
  localparam logic [1:0] CH_SER_A  = 2'h2;
  localparam logic [1:0] CH_SER_B  = 2'h3;
  localparam logic [7:0] CMD_RST_V = 8'h00;
  localparam logic [7:0] FW_RST_V  = 8'h00;

  typedef enum logic [2:0] {
    K_NOOP  = 3'b000,
    K_CHRST = 3'b001,
    K_FULL  = 3'b010,
    K_FLUSH = 3'b011,
    K_OPT   = 3'b100,
    K_SC    = 3'b101,
    K_CTL   = 3'b110
  } kind_t;

  typedef enum logic [2:0] {
    ST_BOOT = 3'b000,
    ST_IDLE = 3'b001,
    ST_DEC  = 3'b010,
    ST_OPT  = 3'b011,
    ST_SCRD = 3'b100,
    ST_SCO  = 3'b101
  } st_t;

  function automatic logic is_serial_f(input logic [1:0] ch);
    return (ch == CH_SER_A) || (ch == CH_SER_B);
  endfunction

  // Returns {hit, slot} of a per-channel byte kept in the register memory.
  function automatic logic [3:0] slot_of_f(input logic [7:0] idx);
    if (idx >= IDX_OPT1 && idx <= IDX_OPT3) begin
      return {1'b1, 3'(idx - IDX_OPT1)};
    end else if (idx >= IDX_SC1 && idx <= IDX_SC4) begin
      return {1'b1, 3'(idx - IDX_SC1) + SLOT_SC1};
    end
    return 4'h0;
  endfunction

  function automatic kind_t cmd_kind_f(input logic [7:0] c);
    kind_t k;
    k = K_NOOP;
    case (c[7:4])
      4'h8: begin
        if (c[6:2] == 5'h00) begin
          if (c[1:0] == 2'h0) k = K_CHRST;
          else if (c[1:0] == 2'h1) k = K_FULL;
          else if (c[1:0] == 2'h2) k = K_FLUSH;
        end
      end
      4'h4: begin
        if (!c[0] && c[3:1] != 3'h0) k = K_OPT;
      end
      4'h2: begin
        if (c[4:3] == 2'h0 && c[2:0] != 3'h0 && c[2:0] <= 3'h4) k = K_SC;
      end
      4'h1: begin
        if (!(c[3] && c[2]) && !(c[1] && c[0]) && c[3:0] != 4'h0) k = K_CTL;
      end
      default: k = K_NOOP;
    endcase
    return k;
  endfunction
endpackage

// File: rtl/chan_regs_mem.sv
// Per-channel register bytes: option registers and special characters.
// Assumes one writer and two readers on the same clock; reads are registered.
`timescale 1ns/10ps
module chan_regs_mem #(
  parameter int AW = 5,
  parameter int DW = 8
) (
  input  wire logic          clk,     // System clock.
  input  wire logic          rst_n,   // Asynchronous reset, active low.
  input  wire logic          clr,     // Zero every byte.
  input  wire logic          we,      // Write strobe.
  input  wire logic [AW-1:0] waddr,   // Write address.
  input  wire logic [DW-1:0] wdata,   // Write data.
  input  wire logic [AW-1:0] raddr_a, // Bus read address.
  input  wire logic [AW-1:0] raddr_b, // Executor read address.
  output logic      [DW-1:0] rdata_a, // Bus read data.
  output logic      [DW-1:0] rdata_b  // Executor read data.
);
  typedef struct packed {
    logic [2**AW-1:0][DW-1:0] mem;
    logic [DW-1:0]            ra;
    logic [DW-1:0]            rb;
  } mem_t;

  mem_t m_ff;
  mem_t nxt_m;

  always_comb begin
    nxt_m    = m_ff;
    nxt_m.ra = m_ff.mem[raddr_a];
    nxt_m.rb = m_ff.mem[raddr_b];
    if (clr) begin
      nxt_m.mem = '0;
    end else if (we) begin
      nxt_m.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      m_ff <= '0;
    end else begin
      m_ff <= nxt_m;
    end
  end

  assign rdata_a = m_ff.ra;
  assign rdata_b = m_ff.rb;
endmodule // chan_regs_mem

// File: verif/tx_side_model.sv
// Transmitter side model that takes the pending special character.
// Assumes the executor's clock and reset; slow adds a stall before taking.
`timescale 1ns/10ps
module tx_side_model (
  input  wire logic       clk,      // System clock.
  input  wire logic       rst_n,    // Reset, active low.
  input  wire logic       sc_valid, // Character pending.
  input  wire logic [7:0] sc_char,  // Character offered.
  input  wire logic       slow,     // Stall before taking.
  output logic            sc_taken, // Take pulse.
  output logic      [7:0] got_char, // Last character taken.
  output logic      [7:0] got_n     // Characters taken.
);
  logic [2:0] wait_ff;
  // The special character jumps the queue, so it goes as soon as the
  // holding register frees; the stall stands for the character in it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sc_taken <= 1'b0;
      got_char <= 8'h00;
      got_n    <= 8'h00;
      wait_ff  <= 3'h0;
    end else begin
      sc_taken <= 1'b0;
      if (sc_valid && !sc_taken) begin
        if (wait_ff >= (slow ? 3'h5 : 3'h0)) begin
          sc_taken <= 1'b1;
          got_char <= sc_char;
          got_n    <= got_n + 8'h01;
          wait_ff  <= 3'h0;
        end else begin
          wait_ff <= wait_ff + 3'h1;
        end
      end
    end
  end
endmodule // tx_side_model

// File: verif/test_channel_command_executor.sv
// Self-checking bench for the channel command executor.
// Assumes the design's APB map and a shortened internal reset count.
`timescale 1ns/10ps
module test_channel_command_executor;
  localparam logic [7:0] FWV = 8'h3c; // Arbitrary nonzero value.
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic        slow    = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, chip_reset, sc_valid, sc_chan, sc_taken, err;
  logic [1:0]  tx_en, rx_en, tx_flush, rx_flush, te, re, chn;
  logic [47:0] opt_shadow;
  logic [7:0]  sc_char, got_char, got_n, n0, b;
  logic [3:0]  p;
  logic [7:0]  sh [2][3];
  logic [7:0]  sc [4];
  int mismatches = 0, samples_checked = 0, cycles = 0;
  int txf_n = 0, rxf_n = 0, chip_n = 0, k0, k1;

  channel_command_executor #(.FW_REV(FWV), .RST_CYC(8), .AW(12)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_en(tx_en), .rx_en(rx_en),
    .tx_flush(tx_flush), .rx_flush(rx_flush), .chip_reset(chip_reset),
    .opt_shadow(opt_shadow), .sc_valid(sc_valid), .sc_char(sc_char),
    .sc_chan(sc_chan), .sc_taken(sc_taken));
  tx_side_model model_u (
    .clk(pclk), .rst_n(presetn), .sc_valid(sc_valid), .sc_char(sc_char),
    .slow(slow), .sc_taken(sc_taken), .got_char(got_char), .got_n(got_n));

  always #5 pclk = ~pclk;

  // Pulses are counted here so that no scenario has to hit their cycle.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (|tx_flush) txf_n <= txf_n + 1;
    if (|rx_flush) rxf_n <= rxf_n + 1;
    if (chip_reset) chip_n <= chip_n + 1;
    if (cycles > 20000) begin
      mismatches++;
      conclude;
    end
  end

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Entered just after a rising edge; leaves one idle cycle behind it.
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) check(1, 0);
    @(posedge pclk);
  endtask

  task automatic poll(input logic [7:0] idx, input logic zero);
    int n;
    n = 0;
    do begin
      apb(1'b0, idx, 32'h0);
      n++;
    end while (((rd === 32'h0) != zero) && n < 60);
  endtask

  task automatic cmd(input logic [1:0] ch, input logic [7:0] c);
    apb(1'b1, chan_cmd_pkg::IDX_CHSEL, {30'h0, ch});
    apb(1'b1, chan_cmd_pkg::IDX_CMD, {24'h0, c});
    poll(chan_cmd_pkg::IDX_CMD, 1'b1);
    check(rd, 0);
  endtask

  initial begin
    void'($urandom(41));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, chan_cmd_pkg::IDX_FWREV, 32'h0);
    check(rd, 0);
    poll(chan_cmd_pkg::IDX_FWREV, 1'b0);
    check(rd, FWV);
    apb(1'b0, chan_cmd_pkg::IDX_CMD, 32'h0);
    check({err, rd}, 0);
    apb(1'b0, 8'h1f, 32'h0);
    check(err, 1);
    n0 = got_n;
    for (int ch = 0; ch < 2; ch++) begin
      cmd(2'(ch), 8'h1a);
      check({tx_en, rx_en}, 0);
      cmd(2'(ch), 8'h21);
    end
    check(got_n, n0);
    te = 2'b00;
    re = 2'b00;
    for (int i = 0; i < 24; i++) begin
      chn = 2'h2 + 2'($urandom % 2);
      p = (i == 0) ? 4'hd : 4'($urandom % 16);
      cmd(chn, {4'h1, p});
      if (!(p[3] && p[2]) && !(p[1] && p[0])) begin
        if (p[3] | p[2]) te[chn[0]] = p[3];
        if (p[1] | p[0]) re[chn[0]] = p[1];
      end
      check({tx_en, rx_en}, {te, re});
    end
    apb(1'b0, chan_cmd_pkg::IDX_STAT, 32'h0);
    check(rd, {27'h0, te, re, 1'b0});
    foreach (sh[c, i]) sh[c][i] = 8'h00;
    for (int j = 0; j < 8; j++) begin
      chn = 2'h2 + 2'($urandom % 2);
      p = 4'(j);
      apb(1'b1, chan_cmd_pkg::IDX_CHSEL, {30'h0, chn});
      for (int i = 0; i < 3; i++) begin
        b = 8'($urandom);
        apb(1'b1, 8'(chan_cmd_pkg::IDX_OPT1 + i), {24'h0, b});
        if (p[i]) sh[chn[0]][i] = b;
      end
      cmd(chn, {4'h4, p[2:0], 1'b0});
      check(opt_shadow, {sh[1][2], sh[1][1], sh[1][0],
                         sh[0][2], sh[0][1], sh[0][0]});
    end
    chn = 2'h3;
    apb(1'b1, chan_cmd_pkg::IDX_CHSEL, {30'h0, chn});
    for (int i = 0; i < 4; i++) begin
      sc[i] = 8'($urandom);
      apb(1'b1, 8'(chan_cmd_pkg::IDX_SC1 + i), {24'h0, sc[i]});
    end
    for (int k = 0; k < 8; k++) begin
      n0 = got_n;
      slow <= 1'($urandom % 2);
      cmd(chn, {5'h04, 3'(k)});
      k0 = (k >= 1 && k <= 4) ? 1 : 0;
      check(got_n, n0 + 8'(k0));
      if (k0 == 1) check(got_char, sc[k - 1]);
      check(sc_chan, chn[0]);
    end
    k0 = txf_n;
    cmd(2'h3, 8'h82);
    check(txf_n, k0 + 1);
    check({tx_en, rx_en}, {te, re});
    cmd(2'h2, 8'h83);
    check({txf_n, tx_en, rx_en}, {k0 + 1, te, re});
    k0 = rxf_n;
    k1 = txf_n;
    apb(1'b1, chan_cmd_pkg::IDX_CHSEL, 32'h2);
    apb(1'b1, chan_cmd_pkg::IDX_CMD, 32'h80);
    apb(1'b0, chan_cmd_pkg::IDX_FWREV, 32'h0);
    check(rd, 0);
    poll(chan_cmd_pkg::IDX_FWREV, 1'b0);
    check(rd, FWV);
    poll(chan_cmd_pkg::IDX_CMD, 1'b1);
    te[0] = 1'b0;
    re[0] = 1'b0;
    check({tx_en, rx_en}, {te, re});
    check(rxf_n, k0 + 1);
    check(txf_n, k1 + 1);
    k0 = chip_n;
    apb(1'b1, chan_cmd_pkg::IDX_FWREV, 32'h0);
    apb(1'b1, chan_cmd_pkg::IDX_CHSEL, 32'h3);
    apb(1'b1, chan_cmd_pkg::IDX_CMD, 32'h81);
    poll(chan_cmd_pkg::IDX_FWREV, 1'b0);
    check(rd, FWV);
    check(chip_n, k0 + 1);
    check({tx_en, rx_en, opt_shadow}, 0);
    apb(1'b0, chan_cmd_pkg::IDX_CHSEL, 32'h0);
    check(rd, 0);
    apb(1'b1, chan_cmd_pkg::IDX_CHSEL, 32'h3);
    apb(1'b0, chan_cmd_pkg::IDX_SC1, 32'h0);
    check(rd, 0);
    conclude;
  end
endmodule // test_channel_command_executor
